// ==== rtl/tcc_cfg.svh ====
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
// =====================================================================
// Register byte offsets
`define TCC_ADDR_CAP_LO     8'h00
`define TCC_ADDR_CAP_HI     8'h01
`define TCC_ADDR_CMPA_LO    8'h02
`define TCC_ADDR_CMPA_HI    8'h03
`define TCC_ADDR_CMPB_LO    8'h04
`define TCC_ADDR_CMPB_HI    8'h05
`define TCC_ADDR_CNT_LO     8'h06
`define TCC_ADDR_CNT_HI     8'h07
`define TCC_ADDR_CTRL_A     8'h08
`define TCC_ADDR_CTRL_B     8'h09
`define TCC_ADDR_FORCE      8'h0A
`define TCC_ADDR_IRQ_MASK   8'h0B
`define TCC_ADDR_IRQ_FLAG   8'h0C
`define TCC_ADDR_CMP_CTRL   8'h0D
// =====================================================================
// Field positions, filter length and fixed top
`define TCC_CTRLB_FILTER    7
`define TCC_CTRLB_EDGE      6
`define TCC_CTRLB_COMPARATOR_CAPTURE_SELECT      5
`define TCC_FLAG_CAP        0
`define TCC_FLAG_CMPA       1
`define TCC_FLAG_CMPB       2
`define TCC_FILTER_LEN      4
`define TCC_TOP_FIXED       16'hFFFF
`endif

// ==== rtl/tcc_pkg.sv ====
package tcc_pkg;
  typedef logic [15:0] tcc_word_t;
  typedef logic [3:0]  tcc_mode_t;
  typedef enum logic [1:0] {
    TCC_ACT_NONE,
    TCC_ACT_TOGGLE,
    TCC_ACT_CLEAR,
    TCC_ACT_SET
  } tcc_action_e;
endpackage : tcc_pkg

// ==== rtl/tcc_compare_channel.sv ====
`timescale 1ns/1ps
`include "tcc_cfg.svh"
// One compare channel: buffer, compare register, match flag and output state.
module tcc_compare_channel (
  input  wire logic        clk,          // System clock.
  input  wire logic        srst,         // Synchronous reset.
  input  wire logic [15:0] timer_count,  // Counter value.
  input  wire logic        tick,         // Timer clock enable pulse.
  input  wire logic        block_match,  // Suppress match this tick.
  input  wire logic        pwm_mode,     // Double buffering active.
  input  wire logic        at_update,    // Counter at ceiling or floor.
  input  wire logic        wr_value,     // Load 16-bit value.
  input  wire logic [15:0] wr_data,      // Value to load.
  input  wire logic        force_strobe, // Force output action.
  input  wire logic [1:0]  action,       // Compare output action.
  input  wire logic        flag_clear,   // Clear the match flag.
  output logic [15:0]      cpu_view,     // Value seen by software.
  output logic [15:0]      active_value, // Value being compared.
  output logic             match_flag,   // Sticky match flag.
  output logic             out_state     // Compare output state.
);
  logic [15:0] buffer_reg;
  logic [15:0] compare_reg;
  logic        flag_reg;
  logic        state_reg;
  logic        match_pend_reg;
  logic        do_action;

  // ====================================================================
  // Buffer and compare register
  always_ff @(posedge clk) begin
    if (srst) begin
      buffer_reg  <= 16'h0000;
      compare_reg <= 16'h0000;
    end else begin
      if (wr_value && pwm_mode) begin
        buffer_reg <= wr_data;
      end
      if (wr_value && !pwm_mode) begin
        compare_reg <= wr_data;
      end else if (pwm_mode && at_update && tick) begin
        compare_reg <= buffer_reg;
      end
    end
  end

  assign cpu_view     = pwm_mode ? buffer_reg : compare_reg;
  assign active_value = compare_reg;

  // ====================================================================
  // Match detection, flag one timer clock after equality
  always_ff @(posedge clk) begin
    if (srst) begin
      match_pend_reg <= 1'b0;
    end else if (tick) begin
      match_pend_reg <= (timer_count == compare_reg) && !block_match;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_reg <= 1'b0;
    end else if (tick && match_pend_reg) begin
      flag_reg <= 1'b1;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  // ====================================================================
  // Output state; action is read live so a change applies at once
  assign do_action = (tick && match_pend_reg) || (force_strobe && !pwm_mode);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= 1'b0;
    end else if (do_action) begin
      case (action)
        2'h1:    state_reg <= ~state_reg;
        2'h2:    state_reg <= 1'b0;
        2'h3:    state_reg <= 1'b1;
        default: state_reg <= state_reg;
      endcase
    end
  end

  assign match_flag = flag_reg;
  assign out_state  = state_reg;
endmodule : tcc_compare_channel

// ==== rtl/tcc_top.sv ====
`timescale 1ns/1ps
`include "tcc_cfg.svh"
// Functional notes
// - A capture copies the whole 16-bit count into the capture register.
// - Capture flag sets with the copy, requests irq, clears on acknowledge.
// - Writing one to the capture flag bit clears it; zero does nothing.
// - Low-byte read of capture latches high byte; high read returns latch.
// - Capture register writable only in modes using it as ceiling.
// - Comparator select swaps trigger source; software clears the spurious flag.
// - Both trigger inputs pass a two-stage synchroniser and edge detector.
// - Filter output changes only after four equal consecutive samples.
// - Filter enable adds four system clocks of latency, prescaler independent.
// - Filter and edge detector are disabled in capture-ceiling modes.
// - A new capture overwrites an unread previous value.
// - Each channel compares continuously; flag one timer clock after match.
// - Compare flag clears on acknowledge or software write of one.
// - Channel A can supply the counter ceiling and waveform period.
// - Compare value double buffered in PWM modes, updated at ceiling/floor.
// - Software reaches buffer when buffering, else compare register directly.
// - Compare high byte latched first; low write loads all 16 bits.
// - Force strobe applies output action in non-PWM modes without flag.
// - Count write suppresses compare matches in the next timer clock.
// - Count written equal to variable ceiling misses match; runs to 0xFFFF.
// - Output state survives mode changes; action changes apply immediately.
// - Reset forces every compare output state to zero.
module tcc_top (
  input  wire logic        clk,            // System clock, 125 MHz.
  input  wire logic        srst,           // Synchronous reset, active high.
  input  wire logic [7:0]  addr,           // Register byte address.
  input  wire logic [7:0]  wr_data,        // Write data.
  input  wire logic        wr_en,          // Write strobe.
  input  wire logic        rd_en,          // Read strobe.
  input  wire logic        timer_tick,     // Timer clock enable pulse.
  input  wire logic        capture_input_pin, // Capture pin, asynchronous.
  input  wire logic        comparator_output, // Comparator, asynchronous.
  input  wire logic [2:0]  irq_ack,        // Acknowledge: capture, A, B.
  output logic [7:0]       rd_data,        // Read data, cycle after strobe.
  output logic [15:0]      timer_count,    // Counter value.
  output logic [2:0]       irq_req,        // Requests: capture, A, B.
  output logic [1:0]       compare_output_state // Channel A, B output.
);
  // ====================================================================
  // Control registers
  logic [7:0]  ctrl_a_reg;           // [1:0] low mode bits
  logic [7:0]  ctrl_b_reg;           // [4:3] high mode bits
  logic [7:0]  irq_mask_reg;
  logic [7:0]  cmp_ctrl_reg;         // [1:0] action A, [3:2] action B
  logic [7:0]  high_byte_latch;
  logic [15:0] capture_value_reg;
  logic        capture_flag;
  logic [15:0] count_reg;
  logic        block_reg;
  tcc_pkg::tcc_mode_t waveform_mode_field;
  logic        noise_filter_enable;
  logic        capture_rising;
  logic        comparator_capture_select;
  logic        cap_is_top;
  logic        cmpa_is_top;
  logic        pwm_mode;
  logic [15:0] count_ceiling;
  logic        wr_cnt_lo;

  assign waveform_mode_field       = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
  assign noise_filter_enable       = ctrl_b_reg[`TCC_CTRLB_FILTER];
  assign capture_rising            = ctrl_b_reg[`TCC_CTRLB_EDGE];
  assign comparator_capture_select = ctrl_b_reg[`TCC_CTRLB_COMPARATOR_CAPTURE_SELECT];
  assign wr_cnt_lo                 = wr_en && (addr == `TCC_ADDR_CNT_LO);

  always_comb begin
    cap_is_top  = 1'b0;
    cmpa_is_top = 1'b0;
    pwm_mode    = 1'b1;
    case (waveform_mode_field)
      4'h0: pwm_mode = 1'b0;
      4'h4: begin
        pwm_mode    = 1'b0;
        cmpa_is_top = 1'b1;
      end
      4'hC: begin
        pwm_mode   = 1'b0;
        cap_is_top = 1'b1;
      end
      4'h8, 4'hA, 4'hE: cap_is_top = 1'b1;
      4'h9, 4'hB, 4'hF: cmpa_is_top = 1'b1;
      4'hD: pwm_mode = 1'b0;
      default: begin
        cap_is_top  = 1'b0;
        cmpa_is_top = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_a_reg   <= 8'h00;
      ctrl_b_reg   <= 8'h00;
      irq_mask_reg <= 8'h00;
      cmp_ctrl_reg <= 8'h00;
    end else if (wr_en) begin
      case (addr)
        `TCC_ADDR_CTRL_A:   ctrl_a_reg   <= wr_data;
        `TCC_ADDR_CTRL_B:   ctrl_b_reg   <= wr_data;
        `TCC_ADDR_IRQ_MASK: irq_mask_reg <= wr_data;
        `TCC_ADDR_CMP_CTRL: cmp_ctrl_reg <= wr_data;
        default: ;
      endcase
    end
  end

  // ====================================================================
  // Trigger synchroniser, filter and edge detector
  logic [1:0]      trig_pins;
  wire logic [1:0] trig_sync;
  logic            trig_sel;
  logic [2:0]      filt_hist_reg;
  logic            filt_out_reg;
  logic            edge_prev_reg;
  logic            det_in;
  logic            cap_event;

  // Each source is synchronised on its own and only then selected, so the
  // source mux never sees a metastable level.
  assign trig_pins = {comparator_output, capture_input_pin};

  genvar src;
  generate
    for (src = 0; src < 2; src = src + 1) begin : g_sync
      logic sync1_reg;
      logic sync2_reg;
      always_ff @(posedge clk) begin
        if (srst) begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
        end else begin
          sync1_reg <= trig_pins[src];
          sync2_reg <= sync1_reg;
        end
      end
      assign trig_sync[src] = sync2_reg;
    end
  endgenerate

  assign trig_sel = comparator_capture_select ? trig_sync[1] : trig_sync[0];

  // The filter judges three stored samples plus the current one, so a clean
  // edge reaches the detector exactly four cycles later than unfiltered.
  always_ff @(posedge clk) begin
    if (srst) begin
      filt_hist_reg <= 3'h0;
      filt_out_reg  <= 1'b0;
    end else if (!cap_is_top) begin
      filt_hist_reg <= {filt_hist_reg[1:0], trig_sel};
      if ({filt_hist_reg, trig_sel} == 4'hF) begin
        filt_out_reg <= 1'b1;
      end else if ({filt_hist_reg, trig_sel} == 4'h0) begin
        filt_out_reg <= 1'b0;
      end
    end
  end

  assign det_in = noise_filter_enable ? filt_out_reg : trig_sel;

  always_ff @(posedge clk) begin
    if (srst) begin
      edge_prev_reg <= 1'b0;
    end else if (!cap_is_top) begin
      edge_prev_reg <= det_in;
    end
  end

  assign cap_event = !cap_is_top &&
                     (capture_rising ? (det_in && !edge_prev_reg)
                                     : (!det_in && edge_prev_reg));

  // ====================================================================
  // Capture register and flag
  logic cap_wr_lo;
  assign cap_wr_lo = wr_en && (addr == `TCC_ADDR_CAP_LO) && cap_is_top;

  always_ff @(posedge clk) begin
    if (srst) begin
      capture_value_reg <= 16'h0000;
    end else if (cap_wr_lo) begin
      capture_value_reg <= {high_byte_latch, wr_data};
    end else if (cap_event) begin
      capture_value_reg <= count_reg;
    end
  end

  // A capture in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk) begin
    if (srst) begin
      capture_flag <= 1'b0;
    end else if (cap_event) begin
      capture_flag <= 1'b1;
    end else if (irq_ack[0] ||
                 (wr_en && addr == `TCC_ADDR_IRQ_FLAG && wr_data[`TCC_FLAG_CAP])) begin
      capture_flag <= 1'b0;
    end
  end

  // ====================================================================
  // Counter with blocking after a software write
  logic [15:0] cmp_a_value;
  logic [15:0] cmp_b_value;
  logic [15:0] cmp_a_view;
  logic [15:0] cmp_b_view;
  logic [1:0]  cmp_flag;
  logic [1:0]  cmp_state;
  logic        at_top;

  assign count_ceiling = cap_is_top ? capture_value_reg :
                         cmpa_is_top ? cmp_a_value : `TCC_TOP_FIXED;

  // A blocked tick also skips the top, so a count written equal to the
  // ceiling runs on to the end of the range.
  assign at_top = (count_reg == count_ceiling) && !block_reg;

  // A software write outranks counting and clearing.
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= 16'h0000;
    end else if (wr_cnt_lo) begin
      count_reg <= {high_byte_latch, wr_data};
    end else if (timer_tick) begin
      count_reg <= at_top ? 16'h0000 : count_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      block_reg <= 1'b0;
    end else if (wr_cnt_lo) begin
      block_reg <= 1'b1;
    end else if (timer_tick) begin
      block_reg <= 1'b0;
    end
  end

  // ====================================================================
  // Compare channels
  // Buffer updates follow the unblocked top, so a missed top also holds them.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      logic [15:0] view;
      logic [15:0] act;
      tcc_compare_channel u_chan (
        .clk          (clk),
        .srst         (srst),
        .timer_count  (count_reg),
        .tick         (timer_tick),
        .block_match  (block_reg),
        .pwm_mode     (pwm_mode),
        .at_update    (at_top || count_reg == 16'h0000),
        .wr_value     (wr_en && addr == 8'(`TCC_ADDR_CMPA_LO + 2 * ch)),
        .wr_data      ({high_byte_latch, wr_data}),
        .force_strobe (wr_en && addr == `TCC_ADDR_FORCE && wr_data[ch]),
        .action       (cmp_ctrl_reg[2*ch+1 -: 2]),
        .flag_clear   (irq_ack[ch+1] ||
                       (wr_en && addr == `TCC_ADDR_IRQ_FLAG && wr_data[ch+1])),
        .cpu_view     (view),
        .active_value (act),
        .match_flag   (cmp_flag[ch]),
        .out_state    (cmp_state[ch])
      );
    end
  endgenerate

  assign cmp_a_view  = g_chan[0].view;
  assign cmp_b_view  = g_chan[1].view;
  assign cmp_a_value = g_chan[0].act;
  assign cmp_b_value = g_chan[1].act;

  // ====================================================================
  // Shared high-byte latch
  always_ff @(posedge clk) begin
    if (srst) begin
      high_byte_latch <= 8'h00;
    end else if (rd_en && addr == `TCC_ADDR_CAP_LO) begin
      high_byte_latch <= capture_value_reg[15:8];
    end else if (rd_en && addr == `TCC_ADDR_CNT_LO) begin
      high_byte_latch <= count_reg[15:8];
    end else if (wr_en && (addr == `TCC_ADDR_CAP_HI || addr == `TCC_ADDR_CMPA_HI ||
                           addr == `TCC_ADDR_CMPB_HI || addr == `TCC_ADDR_CNT_HI)) begin
      high_byte_latch <= wr_data;
    end
  end

  // ====================================================================
  // Read port and outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `TCC_ADDR_CAP_LO:   rd_data <= capture_value_reg[7:0];
        `TCC_ADDR_CAP_HI:   rd_data <= high_byte_latch;
        `TCC_ADDR_CMPA_LO:  rd_data <= cmp_a_view[7:0];
        `TCC_ADDR_CMPA_HI:  rd_data <= cmp_a_view[15:8];
        `TCC_ADDR_CMPB_LO:  rd_data <= cmp_b_view[7:0];
        `TCC_ADDR_CMPB_HI:  rd_data <= cmp_b_view[15:8];
        `TCC_ADDR_CNT_LO:   rd_data <= count_reg[7:0];
        `TCC_ADDR_CNT_HI:   rd_data <= high_byte_latch;
        `TCC_ADDR_CTRL_A:   rd_data <= ctrl_a_reg;
        `TCC_ADDR_CTRL_B:   rd_data <= ctrl_b_reg;
        `TCC_ADDR_IRQ_MASK: rd_data <= irq_mask_reg;
        `TCC_ADDR_IRQ_FLAG: rd_data <= {5'h00, cmp_flag, capture_flag};
        `TCC_ADDR_CMP_CTRL: rd_data <= cmp_ctrl_reg;
        default:            rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // Requests are registered, so they trail the flags by one cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_req <= 3'h0;
    end else begin
      irq_req <= {cmp_flag, capture_flag} & irq_mask_reg[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timer_count <= 16'h0000;
    end else begin
      timer_count <= count_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      compare_output_state <= 2'h0;
    end else begin
      compare_output_state <= cmp_state;
    end
  end
endmodule : tcc_top

// ==== test/tcc_event_src.sv ====
`timescale 1ns/1ps
// =====================================================================
// External event source
// Levels land 3 ns after the request, so every edge falls between
// clock edges the way a truly asynchronous source would.
module tcc_event_src (
  input  wire logic lvl_pin,           // Requested pin level.
  input  wire logic lvl_cmp,           // Requested comparator level.
  output logic      capture_input_pin, // Pin seen by the block.
  output logic      comparator_output  // Comparator seen by the block.
);
  assign #3 capture_input_pin = lvl_pin;
  assign #3 comparator_output = lvl_cmp;
endmodule : tcc_event_src

// ==== test/tcc_top_properties.sv ====
`timescale 1ns/1ps
// =====================================================================
// Port checker
module tcc_top_properties (
  input wire logic       clk,                 // System clock.
  input wire logic       srst,                // Synchronous reset.
  input wire logic       wr_en,               // Write strobe.
  input wire logic       rd_en,               // Read strobe.
  input wire logic       timer_tick,          // Timer clock enable.
  input wire logic       capture_input_pin,   // Capture pin.
  input wire logic       comparator_output,   // Comparator level.
  input wire logic [2:0] irq_ack,             // Acknowledges.
  input wire logic [7:0] rd_data,             // Read data.
  input wire logic [2:0] irq_req,             // Requests.
  input wire logic [1:0] compare_output_state // Output states.
);
  logic [4:0] quiet_reg; // Cycles since a trigger input moved or a write.

  // A write can start a capture (source switch), so it restarts the count.
  always_ff @(posedge clk) begin
    if (srst || wr_en || $changed(capture_input_pin) || $changed(comparator_output))
      quiet_reg <= 5'h00;
    else if (quiet_reg != 5'h1F)
      quiet_reg <= quiet_reg + 5'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_out_reset_zero: assert property ($past(srst) |-> compare_output_state == 2'h0)
    else $error("output state not zero after reset");
  a_out_change_cause: assert property ($changed(compare_output_state) |->
    $past(timer_tick) || $past(timer_tick, 2) || $past(wr_en) || $past(wr_en, 2))
    else $error("output state changed without tick or write");
  a_cap_irq_cause: assert property ($rose(irq_req[0]) |-> quiet_reg < 5'h0E)
    else $error("capture request without input edge");
  a_cap_ack_clears: assert property (irq_ack[0] && quiet_reg > 5'h0E |-> ##2 !irq_req[0])
    else $error("capture request stayed after acknowledge");
  a_cmp_ack_clears: assert property (irq_ack[1] && !timer_tick ##1 !timer_tick |=>
    !irq_req[1])
    else $error("compare request stayed after acknowledge");
  a_cmpa_irq_tick: assert property ($rose(irq_req[1]) |->
    $past(timer_tick, 2) || $past(wr_en, 2))
    else $error("compare A request not timed by timer tick");
  a_cmpb_irq_tick: assert property ($rose(irq_req[2]) |->
    $past(timer_tick, 2) || $past(wr_en, 2))
    else $error("compare B request not timed by timer tick");
  a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside read window");
endmodule : tcc_top_properties

bind tcc_top tcc_top_properties u_props (
  .clk(clk), .srst(srst), .wr_en(wr_en), .rd_en(rd_en), .timer_tick(timer_tick),
  .capture_input_pin(capture_input_pin), .comparator_output(comparator_output),
  .irq_ack(irq_ack), .rd_data(rd_data), .irq_req(irq_req),
  .compare_output_state(compare_output_state)
);

// ==== test/tcc_top_tb.sv ====
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_top_tb;
  logic        clk, srst, wr_en, rd_en, timer_tick, lvl_pin, lvl_cmp;
  logic [7:0]  addr, wr_data, rd_data, v;
  logic [2:0]  irq_ack, irq_req;
  logic [15:0] timer_count, w, c, r, p;
  logic [1:0]  compare_output_state, act, st;
  wire         pin, cmp;
  int          n_fail, check_count, cyc, n0, n1;
  integer      seed;

  tcc_event_src u_src (.lvl_pin(lvl_pin), .lvl_cmp(lvl_cmp),
    .capture_input_pin(pin), .comparator_output(cmp));
  tcc_top u_dut (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .timer_tick(timer_tick), .capture_input_pin(pin),
    .comparator_output(cmp), .irq_ack(irq_ack), .rd_data(rd_data),
    .timer_count(timer_count), .irq_req(irq_req),
    .compare_output_state(compare_output_state));

  // =====================================================================
  // Bench services
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe.
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a + 8'h01, d[15:8]);
    wr(a, d[7:0]);
  endtask : wr16

  task rd16(input logic [7:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
  endtask : rd16

  task ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
    end
  endtask : ticks

  task wait_cap(output int n);
    n = 0;
    while (irq_req[0] !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_cap

  function automatic logic [1:0] out_after(input logic [1:0] s, input logic [1:0] a);
    case (a)
      2'h1: out_after = {s[1], ~s[0]};
      2'h2: out_after = {s[1], 1'b0};
      2'h3: out_after = {s[1], 1'b1};
      default: out_after = s;
    endcase
  endfunction : out_after

  // =====================================================================
  // Scenarios
  initial begin
    {wr_en, rd_en, timer_tick, lvl_pin, lvl_cmp, addr, wr_data, irq_ack} = '0;
    seed = 49;
    srst = 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk("out_reset", 16'(compare_output_state), 16'h0000);
    w = 16'($random(seed));
    wr16(`TCC_ADDR_CMPA_LO, w);
    wr16(`TCC_ADDR_CMPB_LO, w);
    rd16(`TCC_ADDR_CMPA_LO, r);
    chk("cmp_a", r, w);
    wr(`TCC_ADDR_IRQ_MASK, 8'h07);
    wr16(`TCC_ADDR_CNT_LO, w - 16'h0002);
    ticks(6);
    rd(`TCC_ADDR_IRQ_FLAG, v);
    chk("flag_a", 16'(v[1]), 16'h0001);
    chk("irq_a", 16'(irq_req[1]), 16'h0001);
    @(posedge clk);
    irq_ack <= 3'h2;
    @(posedge clk);
    irq_ack <= 3'h0;
    repeat (2) @(posedge clk);
    #1 chk("irq_a_ack", 16'(irq_req[1]), 16'h0000);
    wr16(`TCC_ADDR_CNT_LO, w);
    ticks(2);
    rd(`TCC_ADDR_IRQ_FLAG, v);
    chk("blocked", 16'(v[1]), 16'h0000);
    $display("test compare done");
    st = compare_output_state;
    for (int i = 3; i >= 0; i--) begin
      act = 2'(i);
      wr(`TCC_ADDR_CMP_CTRL, {6'h00, act});
      wr(`TCC_ADDR_FORCE, 8'h01);
      st = out_after(st, act);
      repeat (3) @(posedge clk);
      #1 chk("force", 16'(compare_output_state), 16'(st));
    end
    rd(`TCC_ADDR_IRQ_FLAG, v);
    chk("force_flag", 16'(v[1]), 16'h0000);
    $display("test force done");
    wr(`TCC_ADDR_CTRL_B, 8'h40);
    c = 16'($random(seed));
    wr16(`TCC_ADDR_CNT_LO, c);
    lvl_pin <= 1'b1;
    wait_cap(n0);
    rd16(`TCC_ADDR_CAP_LO, r);
    chk("cap", r, c);
    rd(`TCC_ADDR_IRQ_FLAG, v);
    chk("cap_flag", 16'(v[0]), 16'h0001);
    wr(`TCC_ADDR_IRQ_FLAG, 8'h00);
    rd(`TCC_ADDR_IRQ_FLAG, v);
    chk("flag_w0", 16'(v[0]), 16'h0001);
    wr(`TCC_ADDR_CTRL_B, 8'h80);
    wr(`TCC_ADDR_IRQ_FLAG, 8'h01);
    rd(`TCC_ADDR_IRQ_FLAG, v);
    chk("flag_w1", 16'(v[0]), 16'h0000);
    c = 16'($random(seed));
    wr16(`TCC_ADDR_CNT_LO, c);
    lvl_pin <= 1'b0;
    wait_cap(n1);
    chk("filter_lat", 16'(n1), 16'(n0 + 4));
    rd16(`TCC_ADDR_CAP_LO, r);
    chk("cap_fall", r, c);
    $display("test capture done");
    wr(`TCC_ADDR_CTRL_B, 8'h60);
    wr(`TCC_ADDR_IRQ_FLAG, 8'h01);
    c = 16'($random(seed));
    wr16(`TCC_ADDR_CNT_LO, c);
    lvl_cmp <= 1'b1;
    wait_cap(n1);
    rd16(`TCC_ADDR_CAP_LO, r);
    chk("cap_cmp", r, c);
    repeat (16) @(posedge clk);
    irq_ack <= 3'h1;
    @(posedge clk);
    irq_ack <= 3'h0;
    repeat (2) @(posedge clk);
    #1 chk("irq_cap_ack", 16'(irq_req[0]), 16'h0000);
    wr16(`TCC_ADDR_CAP_LO, w);
    rd16(`TCC_ADDR_CAP_LO, r);
    chk("cap_ro", r, c);
    wr(`TCC_ADDR_CTRL_B, 8'h58);
    wr(`TCC_ADDR_IRQ_FLAG, 8'h01);
    wr16(`TCC_ADDR_CAP_LO, w);
    rd16(`TCC_ADDR_CAP_LO, r);
    chk("cap_rw", r, w);
    lvl_pin <= 1'b1;
    repeat (15) @(posedge clk);
    rd(`TCC_ADDR_IRQ_FLAG, v);
    chk("cap_off", 16'(v[0]), 16'h0000);
    $display("test capture modes done");
    wr(`TCC_ADDR_CTRL_A, 8'h03);
    p = 16'($random(seed));
    wr16(`TCC_ADDR_CMPA_LO, p);
    rd16(`TCC_ADDR_CMPA_LO, r);
    chk("cmp_buf", r, p);
    wr16(`TCC_ADDR_CNT_LO, w);
    ticks(1);
    @(posedge clk);
    #1 chk("top_missed", timer_count, w + 16'h0001);
    wr(`TCC_ADDR_CTRL_A, 8'h00);
    rd16(`TCC_ADDR_CMPA_LO, r);
    chk("cmp_held", r, w);
    wr(`TCC_ADDR_CTRL_A, 8'h03);
    wr16(`TCC_ADDR_CNT_LO, 16'h0000);
    ticks(1);
    wr16(`TCC_ADDR_CNT_LO, p - 16'h0001);
    ticks(2);
    @(posedge clk);
    #1 chk("ceil_wrap", timer_count, 16'h0000);
    wr(`TCC_ADDR_CTRL_A, 8'h00);
    rd16(`TCC_ADDR_CMPA_LO, r);
    chk("cmp_loaded", r, p);
    $display("test pwm done");
    give_verdict();
  end
endmodule : tcc_top_tb
